/* design/orm_core_regs.sv */
// register file, operand sizing and big-endian word transfers of the processor core
`include "orm_regs.svh"

module orm_core_regs
(
	input	wire logic			REF_CLK,
	input	wire logic			RST,
	input	wire logic			OPWORD_VALID,
	input	wire logic [15:0]		OPWORD,
	output	orm_pkg::orm_size_t		OP_SIZE,
	output	logic [2:0]			OP_LENGTH,
	output	logic				OP_PCREL,
	input	wire logic			CMD_VALID,
	input	wire orm_pkg::orm_kind_t	CMD_KIND,
	input	wire orm_pkg::orm_size_t	CMD_SIZE,
	input	wire logic [4:0]		CMD_SRC,
	input	wire logic [4:0]		CMD_DST,
	input	wire logic			CMD_MEM,
	input	wire logic			CMD_TO_MEM,
	input	wire logic			CMD_PCREL,
	input	wire logic [23:0]		CMD_ADDR,
	input	wire logic [7:0]		CMD_IMM,
	input	wire logic [16:0]		CMD_MASK,
	output	logic				CMD_READY,
	output	logic				CMD_DONE,
	output	logic				ADDR_ERROR,
	output	logic				SIZE_ERROR,
	output	logic				BUS_REQ,
	output	logic				BUS_WRITE,
	output	logic				BUS_PROG,
	output	logic				BUS_UPPER,
	output	logic				BUS_LOWER,
	output	logic [23:0]			BUS_ADDR,
	output	logic [15:0]			BUS_WDATA,
	input	wire logic			BUS_ACK,
	input	wire logic [15:0]		BUS_RDATA,
	output	logic [15:0]			STATUS_WORD,
	output	logic [31:0]			RESULT
);
	import orm_pkg::*;

	typedef struct packed {
		orm_state_t	state;
		orm_kind_t	kind;
		orm_size_t	size;
		logic [4:0]	dst;
		logic [4:0]	cur;
		logic		to_mem;
		logic		pcrel;
		logic [16:0]	mask;
		logic [23:0]	addr;
		logic [31:0]	data;
		logic [1:0]	left;
		logic		ready;
		logic		done;
		logic		aerr;
		logic		serr;
		logic		breq;
		logic		bwr;
		logic		bprog;
		logic		bup;
		logic		blo;
		logic [23:0]	baddr;
		logic [15:0]	bwd;
		logic [15:0]	sr;
		logic [31:0]	result;
		orm_size_t	op_size;
		logic [2:0]	op_len;
		logic		op_pcrel;
	} orm_top_t;

	orm_top_t	s;
	orm_top_t	next_s;
	logic [31:0]	rd_data;
	logic		wb;
	logic [4:0]	wb_sel;
	orm_size_t	wb_size;
	logic [31:0]	wb_val;
	logic		wr_en;
	logic [2:0]	wr_lanes;
	logic [31:0]	wr_data;
	orm_size_t	dec_size;
	logic [2:0]	dec_len;
	logic		dec_pcrel;
	logic		cmd_mem;
	logic		odd;
	logic		bad;

	function automatic logic is_addr(input logic [4:0] sel);
		is_addr = sel >= `ORM_ADDR_BASE;
	endfunction

	// sized view of a register as a source
	function automatic logic [31:0] operand(input logic [4:0] sel, input orm_size_t sz,
		input logic [31:0] v);
		if (is_addr(sel))
			operand = (sz == SZ_LONG) ? v : {16'h0, v[15:0]};
		else if (sz == SZ_BYTE)
			operand = {24'h0, v[7:0]};
		else if (sz == SZ_WORD)
			operand = {16'h0, v[15:0]};
		else
			operand = v;
	endfunction

	function automatic logic [2:0] lanes_for(input logic [4:0] sel, input orm_size_t sz);
		if (is_addr(sel) || sz == SZ_LONG)
			lanes_for = `ORM_LANES_LONG;
		else if (sz == SZ_WORD)
			lanes_for = `ORM_LANES_WORD;
		else
			lanes_for = `ORM_LANES_BYTE;
	endfunction

	function automatic logic [4:0] first_bit(input logic [16:0] m);
		first_bit = 5'h00;
		for (int i = 16; i >= 0; i--)
		begin
			if (m[i])
				first_bit = 5'(i);
		end
	endfunction

	function automatic logic [1:0] first_left(input orm_kind_t k, input orm_size_t sz);
		if (k == MK_PERIPH)
			first_left = (sz == SZ_LONG) ? 2'h3 : 2'h1;
		else
			first_left = (sz == SZ_LONG) ? 2'h1 : 2'h0;
	endfunction

	// start one bus cycle for the current word or byte
	function automatic orm_top_t launch(input orm_top_t t);
		logic lane;
		lane = (t.size == SZ_BYTE) || (t.kind == MK_PERIPH);
		t.state = ST_BUS;
		t.breq = 1'b1;
		t.bwr = t.to_mem;
		t.bprog = !t.to_mem && t.pcrel;
		t.baddr = t.addr;
		t.bup = !lane || !t.addr[0];
		t.blo = !lane || t.addr[0];
		if (t.kind == MK_PERIPH)
			t.bwd = {2{t.data[{t.left, 3'b000} +: 8]}};
		else if (t.size == SZ_BYTE)
			t.bwd = {2{t.data[7:0]}};
		else
			t.bwd = t.left[0] ? t.data[31:16] : t.data[15:0];
		return t;
	endfunction

	orm_opdecode u_dec
	(
		.opword	(OPWORD),
		.size	(dec_size),
		.length	(dec_len),
		.pcrel	(dec_pcrel)
	);

	orm_regstore u_store
	(
		.clk		(REF_CLK),
		.rst		(RST),
		.rd_sel		(next_s.cur),
		.wr_en		(wr_en),
		.wr_sel		(wb_sel),
		.wr_lanes	(wr_lanes),
		.wr_data	(wr_data),
		.rd_data	(rd_data)
	);

	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.aerr = 1'b0;
		next_s.serr = 1'b0;
		wb = 1'b0;
		wb_sel = s.dst;
		wb_size = s.size;
		wb_val = 32'h0;
		cmd_mem = CMD_MEM || CMD_KIND == MK_MULTI || CMD_KIND == MK_PERIPH;
		odd = CMD_ADDR[0] && (CMD_KIND == MK_MULTI ||
			(cmd_mem && CMD_KIND != MK_PERIPH && CMD_SIZE != SZ_BYTE));
		bad = !(CMD_SIZE inside {SZ_BYTE, SZ_WORD, SZ_LONG}) || CMD_SRC > `ORM_SSP_IDX ||
			CMD_DST > `ORM_SSP_IDX || (CMD_KIND == MK_ADDR && !is_addr(CMD_DST)) ||
			(CMD_SIZE == SZ_BYTE && (CMD_KIND == MK_ADDR || CMD_KIND == MK_MULTI ||
			(is_addr(CMD_SRC) && !(cmd_mem && !CMD_TO_MEM)) ||
			(is_addr(CMD_DST) && !(cmd_mem && CMD_TO_MEM))));
		if (OPWORD_VALID)
		begin
			next_s.op_size = dec_size;
			next_s.op_len = dec_len;
			next_s.op_pcrel = dec_pcrel;
		end
		unique case (s.state)
			ST_IDLE:
			begin
				if (CMD_VALID && s.ready)
				begin
					next_s.kind = CMD_KIND;
					next_s.size = CMD_SIZE;
					next_s.addr = CMD_ADDR;
					next_s.pcrel = CMD_PCREL;
					next_s.to_mem = CMD_TO_MEM && cmd_mem;
					next_s.data = 32'h0;
					next_s.cur = (CMD_KIND == MK_USP_FROM) ? `ORM_USP_IDX : CMD_SRC;
					next_s.dst = (CMD_KIND == MK_USP_TO) ? `ORM_USP_IDX : CMD_DST;
					if (CMD_KIND == MK_USP_TO || CMD_KIND == MK_USP_FROM)
						next_s.size = SZ_LONG;
					next_s.left = first_left(CMD_KIND, next_s.size);
					if (odd)
					begin
						next_s.aerr = 1'b1;
						next_s.done = 1'b1;
					end
					else if (bad)
					begin
						next_s.serr = 1'b1;
						next_s.done = 1'b1;
					end
					else
					begin
						unique case (CMD_KIND)
							MK_QUICK:
							begin
								wb = 1'b1;
								wb_sel = CMD_DST;
								wb_size = SZ_LONG;
								wb_val = {{24{CMD_IMM[7]}}, CMD_IMM};
								next_s.done = 1'b1;
							end
							MK_SR_READ:
							begin
								wb = 1'b1;
								wb_sel = CMD_DST;
								wb_size = SZ_WORD;
								wb_val = {16'h0, s.sr};
								next_s.done = 1'b1;
							end
							MK_MULTI:
							begin
								next_s.mask = CMD_MASK;
								next_s.cur = first_bit(CMD_MASK);
								if (CMD_MASK == 17'h0)
									next_s.done = 1'b1;
								else if (next_s.to_mem)
									next_s.state = ST_EXEC;
								else
									next_s = launch(next_s);
							end
							MK_PLAIN, MK_ADDR, MK_SR_WRITE, MK_CCR_WRITE, MK_USP_TO,
							MK_USP_FROM, MK_PERIPH:
							begin
								if (cmd_mem && !next_s.to_mem)
									next_s = launch(next_s);
								else
									next_s.state = ST_EXEC;
							end
							default:
							begin
								next_s.serr = 1'b1;
								next_s.done = 1'b1;
							end
						endcase
					end
				end
			end
			ST_EXEC:
			begin
				if (s.kind == MK_SR_WRITE)
				begin
					next_s.sr = rd_data[15:0];
					next_s.done = 1'b1;
					next_s.state = ST_IDLE;
				end
				else if (s.kind == MK_CCR_WRITE)
				begin
					next_s.sr[7:0] = rd_data[7:0];
					next_s.done = 1'b1;
					next_s.state = ST_IDLE;
				end
				else if (s.to_mem)
				begin
					next_s.data = (s.kind == MK_MULTI) ? rd_data : operand(s.cur, s.size, rd_data);
					next_s = launch(next_s);
				end
				else
				begin
					wb = 1'b1;
					wb_val = operand(s.cur, s.size, rd_data);
					next_s.done = 1'b1;
					next_s.state = ST_IDLE;
				end
			end
			ST_BUS:
			begin
				if (BUS_ACK)
				begin
					next_s.breq = 1'b0;
					next_s.addr = s.addr + `ORM_WORD_STEP;
					if (!s.bwr && (s.bup ^ s.blo))
						next_s.data = {s.data[23:0], s.blo ? BUS_RDATA[7:0] : BUS_RDATA[15:8]};
					else if (!s.bwr)
						next_s.data = {s.data[15:0], BUS_RDATA};
					if (s.left != 2'h0)
					begin
						next_s.left = s.left - 2'h1;
						next_s = launch(next_s);
					end
					else if (s.kind == MK_MULTI)
					begin
						if (!s.to_mem)
						begin
							wb = 1'b1;
							wb_sel = s.cur;
							wb_size = SZ_LONG;
							wb_val = (s.size == SZ_LONG) ? next_s.data :
								{{16{next_s.data[15]}}, next_s.data[15:0]};
						end
						next_s.mask[s.cur] = 1'b0;
						next_s.cur = first_bit(next_s.mask);
						next_s.left = first_left(s.kind, s.size);
						next_s.state = ST_IDLE;
						if (next_s.mask == 17'h0)
							next_s.done = 1'b1;
						else if (s.to_mem)
							next_s.state = ST_EXEC;
						else
							next_s = launch(next_s);
					end
					else
					begin
						wb = !s.to_mem;
						wb_val = next_s.data;
						next_s.done = 1'b1;
						next_s.state = ST_IDLE;
					end
				end
			end
			default:
				next_s.state = ST_IDLE;
		endcase
		// address destinations take sign-extended word results in full
		wr_en = wb;
		wr_lanes = lanes_for(wb_sel, wb_size);
		if (is_addr(wb_sel) && wb_size != SZ_LONG)
			wr_data = {{16{wb_val[15]}}, wb_val[15:0]};
		else
			wr_data = wb_val;
		if (wb)
			next_s.result = wr_data;
		next_s.ready = next_s.state == ST_IDLE;
	end

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			s <= '0;
			s.sr <= `ORM_SR_RESET;
		end
		else
			s <= next_s;
	end

	assign OP_SIZE = s.op_size;
	assign OP_LENGTH = s.op_len;
	assign OP_PCREL = s.op_pcrel;
	assign CMD_READY = s.ready;
	assign CMD_DONE = s.done;
	assign ADDR_ERROR = s.aerr;
	assign SIZE_ERROR = s.serr;
	assign BUS_REQ = s.breq;
	assign BUS_WRITE = s.bwr;
	assign BUS_PROG = s.bprog;
	assign BUS_UPPER = s.bup;
	assign BUS_LOWER = s.blo;
	assign BUS_ADDR = s.baddr;
	assign BUS_WDATA = s.bwd;
	assign STATUS_WORD = s.sr;
	assign RESULT = s.result;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	AST_ODD_REFUSED: assert property (
		CMD_VALID && CMD_READY && odd |=> ADDR_ERROR && CMD_DONE && !BUS_REQ)
		else $error("odd word access not refused");
	AST_WORD_EVEN: assert property (
		BUS_REQ && BUS_UPPER && BUS_LOWER |-> !BUS_ADDR[0])
		else $error("word cycle at odd address");
	AST_WRITE_DATA: assert property (
		BUS_REQ && BUS_WRITE |-> !BUS_PROG)
		else $error("write marked as program space");
	AST_READ_SPACE: assert property (
		BUS_REQ && !BUS_WRITE |-> BUS_PROG == s.pcrel)
		else $error("read space class wrong");
	AST_LONG_SECOND: assert property (
		BUS_REQ && BUS_ACK && s.size == SZ_LONG && s.kind != MK_PERIPH && s.left == 2'h1
		|=> BUS_REQ && BUS_ADDR == $past(BUS_ADDR) + 24'h000002 && s.left == 2'h0)
		else $error("second word of long not at n+2");
	AST_HIGH_FIRST: assert property (
		BUS_REQ && BUS_WRITE && s.size == SZ_LONG && s.kind != MK_PERIPH && s.left == 2'h1
		|-> BUS_WDATA == s.data[31:16])
		else $error("long word high half not first");
	AST_BYTE_LANE: assert property (
		BUS_REQ && s.size == SZ_BYTE |-> BUS_UPPER == !BUS_ADDR[0] && BUS_LOWER == BUS_ADDR[0])
		else $error("byte lane does not follow address parity");
	AST_ADDR_FULL: assert property (
		wr_en && is_addr(wb_sel) |-> wr_lanes == `ORM_LANES_LONG)
		else $error("address register partly written");
	AST_SIGN_EXT: assert property (
		wr_en && is_addr(wb_sel) && wb_size == SZ_WORD |-> wr_data[31:16] == {16{wr_data[15]}})
		else $error("word into address register not sign-extended");
	AST_CCR_ONLY: assert property (
		s.state == ST_EXEC && s.kind == MK_CCR_WRITE
		|=> STATUS_WORD[15:8] == $past(STATUS_WORD[15:8]) && CMD_DONE)
		else $error("condition byte write touched upper status");
	AST_LENGTH: assert property (
		OPWORD_VALID |=> OP_LENGTH >= 3'h1 && OP_LENGTH <= 3'h5)
		else $error("instruction length out of range");

	COV_LONG_WRITE: cover property (BUS_REQ && BUS_WRITE && s.size == SZ_LONG ##[1:20] CMD_DONE);
	COV_MULTI: cover property (s.kind == MK_MULTI && BUS_ACK ##[1:40] s.kind == MK_MULTI && CMD_DONE);
	COV_PERIPH: cover property (s.kind == MK_PERIPH && BUS_REQ && BUS_LOWER && !BUS_UPPER);
	COV_PCREL: cover property (BUS_REQ && BUS_PROG);
endmodule

/* design/orm_regs.svh */
// register indices, lane masks, operation word fields and reset values
`ifndef ORM_REGS_SVH
`define ORM_REGS_SVH

`define ORM_ADDR_BASE		5'h08
`define ORM_USP_IDX		5'h0f
`define ORM_SSP_IDX		5'h10
`define ORM_SR_RESET		16'h0000
`define ORM_LANES_BYTE		3'h1
`define ORM_LANES_WORD		3'h3
`define ORM_LANES_LONG		3'h7
`define ORM_WORD_STEP		24'h000002
`define ORM_OPW_SIZE		7:6
`define ORM_OPW_IMPL_LONG	8
`define ORM_OPW_SRC_MODE	5:3
`define ORM_OPW_SRC_REG		2:0
`define ORM_OPW_DST_MODE	8:6
`define ORM_OPW_DST_REG		11:9
`define ORM_OPW_GROUP		15:14
`define ORM_GROUP_MOVE		2'h0
`define ORM_SIZE_IMPLICIT	2'h3
`define ORM_MODE_DISP		3'h5
`define ORM_MODE_INDEX		3'h6
`define ORM_MODE_SPECIAL	3'h7
`define ORM_REG_ABS_SHORT	3'h0
`define ORM_REG_ABS_LONG	3'h1
`define ORM_REG_PC_DISP		3'h2
`define ORM_REG_PC_INDEX	3'h3
`define ORM_REG_IMM		3'h4

`endif

/* design/orm_pkg.sv */
// types shared by the register file block
package orm_pkg;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00,
		SZ_WORD = 2'b01,
		SZ_LONG = 2'b10
	} orm_size_t;

	typedef enum logic [3:0] {
		MK_PLAIN     = 4'b0000,
		MK_ADDR      = 4'b0001,
		MK_QUICK     = 4'b0010,
		MK_SR_READ   = 4'b0011,
		MK_SR_WRITE  = 4'b0100,
		MK_CCR_WRITE = 4'b0101,
		MK_USP_TO    = 4'b0110,
		MK_USP_FROM  = 4'b0111,
		MK_MULTI     = 4'b1000,
		MK_PERIPH    = 4'b1001
	} orm_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_BUS  = 2'b10
	} orm_state_t;
endpackage

/* design/orm_opdecode.sv */
// operation word decode: operand size, instruction length, program-relative source
`include "orm_regs.svh"

module orm_opdecode
(
	input	wire logic [15:0]		opword,
	output	orm_pkg::orm_size_t		size,
	output	logic [2:0]			length,
	output	logic				pcrel
);
	import orm_pkg::*;

	logic [1:0]	src_ext;
	logic [1:0]	dst_ext;

	function automatic logic [1:0] ext_words(input logic [2:0] mode, input logic [2:0] rg,
		input orm_size_t sz);
		ext_words = 2'h0;
		if (mode == `ORM_MODE_DISP || mode == `ORM_MODE_INDEX)
			ext_words = 2'h1;
		else if (mode == `ORM_MODE_SPECIAL)
		begin
			unique case (rg)
				`ORM_REG_ABS_SHORT, `ORM_REG_PC_DISP, `ORM_REG_PC_INDEX: ext_words = 2'h1;
				`ORM_REG_ABS_LONG: ext_words = 2'h2;
				`ORM_REG_IMM: ext_words = (sz == SZ_LONG) ? 2'h2 : 2'h1;
				default: ext_words = 2'h0;
			endcase
		end
	endfunction

	always_comb
	begin
		// explicit size field, else implied by the operation (word or long only)
		if (opword[`ORM_OPW_SIZE] == `ORM_SIZE_IMPLICIT)
			size = opword[`ORM_OPW_IMPL_LONG] ? SZ_LONG : SZ_WORD;
		else
			size = orm_size_t'(opword[`ORM_OPW_SIZE]);
		src_ext = ext_words(opword[`ORM_OPW_SRC_MODE], opword[`ORM_OPW_SRC_REG], size);
		dst_ext = 2'h0;
		if (opword[`ORM_OPW_GROUP] == `ORM_GROUP_MOVE)
			dst_ext = ext_words(opword[`ORM_OPW_DST_MODE], opword[`ORM_OPW_DST_REG], size);
		length = 3'h1 + {1'b0, src_ext} + {1'b0, dst_ext};
		pcrel = opword[`ORM_OPW_SRC_MODE] == `ORM_MODE_SPECIAL &&
			(opword[`ORM_OPW_SRC_REG] == `ORM_REG_PC_DISP ||
			opword[`ORM_OPW_SRC_REG] == `ORM_REG_PC_INDEX);
	end
endmodule

/* design/orm_regstore.sv */
// seventeen 32-bit registers with lane write enables and registered read
`include "orm_regs.svh"

module orm_regstore
(
	input	wire logic		clk,
	input	wire logic		rst,
	input	wire logic [4:0]	rd_sel,
	input	wire logic		wr_en,
	input	wire logic [4:0]	wr_sel,
	input	wire logic [2:0]	wr_lanes,
	input	wire logic [31:0]	wr_data,
	output	logic [31:0]		rd_data
);
	typedef struct packed {
		logic [16:0][31:0]	regs;
		logic [31:0]		rd_data;
	} orm_store_t;

	orm_store_t	s;
	orm_store_t	next_s;
	logic [15:0]	upper_sel;

	always_comb
	begin
		next_s = s;
		for (int i = 0; i < 17; i++)
		begin
			if (wr_en && wr_sel == 5'(i))
			begin
				// unselected lanes keep their value
				if (wr_lanes[0])
					next_s.regs[i][7:0] = wr_data[7:0];
				if (wr_lanes[1])
					next_s.regs[i][15:8] = wr_data[15:8];
				if (wr_lanes[2])
					next_s.regs[i][31:16] = wr_data[31:16];
			end
		end
		next_s.rd_data = (rd_sel <= `ORM_SSP_IDX) ? s.regs[rd_sel] : 32'h0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign rd_data = s.rd_data;
	assign upper_sel = (wr_sel <= `ORM_SSP_IDX) ? s.regs[wr_sel][31:16] : 16'h0;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_UPPER_KEPT: assert property (
		wr_en && !wr_lanes[2] && wr_sel <= `ORM_SSP_IDX
		|=> s.regs[$past(wr_sel)][31:16] == $past(upper_sel))
		else $error("upper half changed on a narrow write");
	AST_LOW_TAKEN: assert property (
		wr_en && wr_lanes[0] && wr_sel <= `ORM_SSP_IDX
		|=> s.regs[$past(wr_sel)][7:0] == 8'($past(wr_data)))
		else $error("low byte not written");
endmodule

/* tb/orm_mem_model.sv */
// big-endian word memory on the far side of the core bus port
module orm_mem_model
(
	input	wire logic		clk,
	input	wire logic		rst,
	input	wire logic [3:0]	lat,
	input	wire logic		bus_req,
	input	wire logic		bus_write,
	input	wire logic		bus_upper,
	input	wire logic		bus_lower,
	input	wire logic [23:0]	bus_addr,
	input	wire logic [15:0]	bus_wdata,
	output	logic			bus_ack,
	output	logic [15:0]		bus_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]	mem [0:255];
	logic [3:0]	cnt;
	logic [7:0]	a;
	assign a = {bus_addr[7:1], 1'b0};
	initial
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i * 7 + 3);
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bus_ack <= 1'b0;
			cnt <= 4'h0;
			bus_rdata <= 16'h0000;
		end
		else if (bus_req && !bus_ack)
		begin
			cnt <= (cnt >= lat) ? 4'h0 : cnt + 4'h1;
			bus_ack <= (cnt >= lat);
			if (cnt >= lat)
				bus_rdata <= {mem[a], mem[a + 8'h01]};
		end
		else
		begin
			if (bus_req && bus_write && bus_upper)
				mem[a] <= bus_wdata[15:8];
			if (bus_req && bus_write && bus_lower)
				mem[a + 8'h01] <= bus_wdata[7:0];
			bus_ack <= 1'b0;
			bus_rdata <= ~bus_rdata;
		end
	end
endmodule

/* tb/tb.sv */
// self-checking bench for the core register file block
module tb;
	import orm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic		clk = 1'b0;
	logic		rst = 1'b1;
	logic		op_v = 1'b0;
	logic [15:0]	op_w = 16'h0000;
	orm_size_t	op_size;
	logic [2:0]	op_len;
	logic		op_pc;
	logic		c_v = 1'b0;
	orm_kind_t	c_kind = MK_PLAIN;
	orm_size_t	c_size = SZ_LONG;
	logic [4:0]	c_src = 5'h00;
	logic [4:0]	c_dst = 5'h00;
	logic [2:0]	c_flg = 3'h0;
	logic [23:0]	c_addr = 24'h000000;
	logic [7:0]	c_imm = 8'h00;
	logic [16:0]	c_mask = 17'h00000;
	logic		rdy, done, aerr, serr, breq, bwr, bprog, bup, blo, back;
	logic [23:0]	baddr;
	logic [15:0]	bwd, brd, status;
	logic [31:0]	result;
	logic [3:0]	lat = 4'h0;
	int		errors = 0;
	int		checks = 0;
	logic		got_a, got_s;
	logic		prog_seen, req_seen;
	logic		wr_prog = 1'b0;

	always #12.5 clk = ~clk;

	orm_core_regs i_dut
	(
		.REF_CLK(clk), .RST(rst), .OPWORD_VALID(op_v), .OPWORD(op_w),
		.OP_SIZE(op_size), .OP_LENGTH(op_len), .OP_PCREL(op_pc),
		.CMD_VALID(c_v), .CMD_KIND(c_kind), .CMD_SIZE(c_size),
		.CMD_SRC(c_src), .CMD_DST(c_dst), .CMD_MEM(c_flg[2]),
		.CMD_TO_MEM(c_flg[1]), .CMD_PCREL(c_flg[0]), .CMD_ADDR(c_addr),
		.CMD_IMM(c_imm), .CMD_MASK(c_mask), .CMD_READY(rdy), .CMD_DONE(done),
		.ADDR_ERROR(aerr), .SIZE_ERROR(serr), .BUS_REQ(breq), .BUS_WRITE(bwr),
		.BUS_PROG(bprog), .BUS_UPPER(bup), .BUS_LOWER(blo), .BUS_ADDR(baddr),
		.BUS_WDATA(bwd), .BUS_ACK(back), .BUS_RDATA(brd),
		.STATUS_WORD(status), .RESULT(result)
	);

	orm_mem_model i_mem
	(
		.clk(clk), .rst(rst), .lat(lat), .bus_req(breq), .bus_write(bwr),
		.bus_upper(bup), .bus_lower(blo), .bus_addr(baddr), .bus_wdata(bwd),
		.bus_ack(back), .bus_rdata(brd)
	);

	always @(negedge clk)
		if (breq === 1'b1)
		begin
			req_seen = 1'b1;
			prog_seen = prog_seen | (bprog === 1'b1);
			if (bwr === 1'b1 && bprog !== 1'b0)
				wr_prog = 1'b1;
		end

	function automatic logic [7:0] pat(input int i);
		return 8'(i * 7 + 3);
	endfunction

	function automatic logic [31:0] m4(input int a);
		return {i_mem.mem[a], i_mem.mem[a + 1], i_mem.mem[a + 2], i_mem.mem[a + 3]};
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic final_report;
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic dec(input logic [15:0] w, input orm_size_t s, input logic [2:0] l,
		input logic p);
		@(posedge clk);
		op_v <= 1'b1;
		op_w <= w;
		@(posedge clk);
		op_v <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk("op_size", s, op_size);
		chk("op_length", l, op_len);
		chk("op_pcrel", p, op_pc);
	endtask

	// flags are {memory, to memory, program relative}; ad doubles as quick value
	task automatic cmd(input orm_kind_t k, input orm_size_t s, input logic [4:0] sr,
		input logic [4:0] ds, input logic [2:0] f, input logic [23:0] ad, input logic [16:0] mk);
		int n;
		@(posedge clk);
		c_v <= 1'b1;
		c_kind <= k;
		c_size <= s;
		c_src <= sr;
		c_dst <= ds;
		c_flg <= f;
		c_addr <= ad;
		c_imm <= ad[7:0];
		c_mask <= mk;
		req_seen = 1'b0;
		prog_seen = 1'b0;
		@(negedge clk);
		for (n = 0; rdy !== 1'b1 && n < 50; n++)
			@(negedge clk);
		@(posedge clk);
		c_v <= 1'b0;
		for (n = 0; n < 60; n++)
		begin
			@(negedge clk);
			if (done === 1'b1)
				break;
		end
		chk("done", 1'b1, done);
		got_a = aerr;
		got_s = serr;
	endtask

	initial
	begin
		#200us;
		errors++;
		final_report;
	end

	initial
	begin
		@(posedge clk);
		@(negedge clk);
		chk("ready_in_reset", 1'b0, rdy);
		chk("status_reset", 16'h0000, status);
		@(posedge clk);
		rst <= 1'b0;
		dec(16'h4080, SZ_LONG, 3'h1, 1'b0);
		dec(16'h40fc, SZ_WORD, 3'h2, 1'b0);
		dec(16'h41fc, SZ_LONG, 3'h3, 1'b0);
		dec(16'h403a, SZ_BYTE, 3'h2, 1'b1);
		dec(16'h4068, SZ_WORD, 3'h2, 1'b0);
		dec(16'h03f9, SZ_LONG, 3'h5, 1'b0);
		cmd(MK_QUICK, SZ_LONG, 5'h00, 5'h02, 3'h0, 24'h000085, 17'h00000);
		chk("quick", 32'hffffff85, result);
		cmd(MK_QUICK, SZ_LONG, 5'h00, 5'h01, 3'h0, 24'h00007f, 17'h00000);
		cmd(MK_PLAIN, SZ_BYTE, 5'h02, 5'h01, 3'h0, 24'h000000, 17'h00000);
		chk("byte_move", 32'h00000085, result);
		cmd(MK_PLAIN, SZ_WORD, 5'h02, 5'h01, 3'h0, 24'h000000, 17'h00000);
		chk("word_move", 32'h0000ff85, result);
		cmd(MK_ADDR, SZ_WORD, 5'h01, 5'h08, 3'h0, 24'h000000, 17'h00000);
		chk("addr_word", 32'hffffff85, result);
		cmd(MK_PLAIN, SZ_WORD, 5'h08, 5'h03, 3'h0, 24'h000000, 17'h00000);
		chk("addr_src_word", 32'h0000ff85, result);
		cmd(MK_ADDR, SZ_LONG, 5'h02, 5'h09, 3'h0, 24'h000000, 17'h00000);
		cmd(MK_PLAIN, SZ_LONG, 5'h09, 5'h03, 3'h0, 24'h000000, 17'h00000);
		chk("addr_src_long", 32'hffffff85, result);
		cmd(MK_PLAIN, SZ_BYTE, 5'h08, 5'h03, 3'h0, 24'h000000, 17'h00000);
		chk("addr_byte", 1'b1, got_s);
		cmd(MK_PLAIN, orm_size_t'(2'h3), 5'h01, 5'h02, 3'h0, 24'h000000, 17'h00000);
		chk("bad_size", 1'b1, got_s);
		cmd(MK_ADDR, SZ_WORD, 5'h01, 5'h04, 3'h0, 24'h000000, 17'h00000);
		chk("addr_move_to_data", 1'b1, got_s);
		cmd(MK_SR_WRITE, SZ_WORD, 5'h01, 5'h00, 3'h0, 24'h000000, 17'h00000);
		chk("status_write", 16'hff85, status);
		cmd(MK_QUICK, SZ_LONG, 5'h00, 5'h06, 3'h0, 24'h00003c, 17'h00000);
		cmd(MK_CCR_WRITE, SZ_BYTE, 5'h06, 5'h00, 3'h0, 24'h000000, 17'h00000);
		chk("cond_byte_write", 16'hff3c, status);
		cmd(MK_SR_READ, SZ_WORD, 5'h00, 5'h07, 3'h0, 24'h000000, 17'h00000);
		chk("status_read", 32'h0000ff3c, result);
		cmd(MK_USP_TO, SZ_LONG, 5'h01, 5'h0f, 3'h0, 24'h000000, 17'h00000);
		cmd(MK_USP_FROM, SZ_LONG, 5'h0f, 5'h00, 3'h0, 24'h000000, 17'h00000);
		chk("user_sp", 32'h0000ff85, result);
		lat <= 4'h3;
		cmd(MK_PLAIN, SZ_LONG, 5'h01, 5'h00, 3'h6, 24'h000010, 17'h00000);
		chk("long_write", 32'h0000ff85, m4(16));
		cmd(MK_PLAIN, SZ_LONG, 5'h00, 5'h04, 3'h5, 24'h000020, 17'h00000);
		chk("long_read", {pat(32), pat(33), pat(34), pat(35)}, result);
		chk("prog_read", 1'b1, prog_seen);
		cmd(MK_PLAIN, SZ_BYTE, 5'h00, 5'h05, 3'h4, 24'h000021, 17'h00000);
		chk("odd_byte_read", {24'h000000, pat(33)}, result);
		chk("data_read", 1'b0, prog_seen);
		lat <= 4'h0;
		cmd(MK_PLAIN, SZ_LONG, 5'h00, 5'h04, 3'h4, 24'h000023, 17'h00000);
		chk("odd_long", 1'b1, got_a);
		chk("odd_long_bus", 1'b0, req_seen);
		cmd(MK_MULTI, SZ_LONG, 5'h00, 5'h00, 3'h6, 24'h000040, 17'h00102);
		chk("multi_first", 32'h0000ff85, m4(64));
		chk("multi_second", 32'hffffff85, m4(68));
		cmd(MK_PERIPH, SZ_WORD, 5'h01, 5'h00, 3'h6, 24'h000061, 17'h00000);
		chk("periph", 16'hff85, {i_mem.mem[97], i_mem.mem[99]});
		chk("write_space", 1'b0, wr_prog);
		final_report;
	end
endmodule
